// ==== design/acf_pkg.sv ====
package acf_pkg;
	// register indices as printed, byte address is four times the index
	localparam int ADDR_W = 18;
	localparam logic [15:0] AUX_IDX = 16'h00a2;
	localparam logic [15:0] FRZ_IDX = 16'hffd0;
	localparam logic [ADDR_W-1:0] AUX_ADDR = {AUX_IDX, 2'b00};
	localparam logic [ADDR_W-1:0] FRZ_ADDR = {FRZ_IDX, 2'b00};
	// auxiliary_control fields
	localparam int AUX_SEL_BIT = 0;
	localparam int AUX_SPARE_BIT = 1;
	localparam int AUX_SOFT_RESET_REQUEST_BIT = 3;
	localparam int AUX_TA_BIT = 4;
	localparam int AUX_TB_BIT = 5;
	localparam int AUX_BRK_BIT = 6;
	localparam int AUX_CLP_BIT = 7;
	localparam logic [7:0] AUX_WMASK = 8'hf1;
	localparam logic [7:0] AUX_RST = 8'h00;
	// debug_clock_freeze fields
	localparam int FRZ_TA_BIT = 0;
	localparam int FRZ_TB_BIT = 1;
	localparam int FRZ_WD_BIT = 2;
	localparam int FRZ_RTC_BIT = 4;
	localparam logic [7:0] FRZ_WMASK = 8'h17;
	localparam logic [7:0] FRZ_RST = 8'h00;
	// debug enable bit inside user_config_word_two
	localparam int DBG_CFG_BIT = 5;
	localparam logic [15:0] DP_RST = 16'h0000;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_DECERR = 2'b11;
	localparam int DBG_PINS = 3;

	typedef enum logic [1:0] {
		WS_IDLE = 2'b00,
		WS_ADDR = 2'b01,
		WS_RESP = 2'b11,
		WS_DATA = 2'b10
	} acf_wstate_t;

	// core-side data pointer operation
	typedef struct packed {
		logic inc;
		logic load;
		logic wr_high;
		logic wr_low;
		logic [15:0] value;
	} acf_dp_op_t;

	// peripheral clock enables, high means clocked
	typedef struct packed {
		logic rtc;
		logic watchdog;
		logic timer_b;
		logic timer_a;
	} acf_clk_en_t;
endpackage : acf_pkg

// ==== design/acf_data_pointer_bank.sv ====
`timescale 1ns/100ps
module acf_data_pointer_bank
	import acf_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic pointer_select,
	input acf_dp_op_t dp_op,
	output logic [15:0] pointer_q
);
	logic [15:0] ptr_reg [2];
	logic [15:0] rd_reg;

	// only the selected entry moves, the other one is held untouched
	for (genvar i = 0; i < 2; i++) begin : g_ptr
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				ptr_reg[i] <= DP_RST;
			end else if (pointer_select == 1'(i)) begin
				if (dp_op.load) begin
					ptr_reg[i] <= dp_op.value;
				end else if (dp_op.inc) begin
					ptr_reg[i] <= ptr_reg[i] + 16'h0001;
				end else begin
					if (dp_op.wr_high) begin
						ptr_reg[i][15:8] <= dp_op.value[15:8];
					end
					if (dp_op.wr_low) begin
						ptr_reg[i][7:0] <= dp_op.value[7:0];
					end
				end
			end
		end
	end

	// registered read port, shows the selected entry one cycle late
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rd_reg <= DP_RST;
		end else begin
			rd_reg <= ptr_reg[pointer_select];
		end
	end
	assign pointer_q = rd_reg;

	property p_hidden_kept;
		@(posedge aclk) disable iff (!aresetn)
		(pointer_select == 1'b0) |=> $stable(ptr_reg[1]);
	endproperty
	a_hidden_kept: assert property (p_hidden_kept) else $error("unselected pointer changed");

	property p_load_seen;
		@(posedge aclk) disable iff (!aresetn)
		dp_op.load ##1 $stable(pointer_select) |=> pointer_q == $past(dp_op.value, 2);
	endproperty
	a_load_seen: assert property (p_load_seen) else $error("loaded pointer not shown");
endmodule : acf_data_pointer_bank

// ==== design/acf_aux_ctrl.sv ====
`timescale 1ns/100ps
module acf_aux_ctrl
	import acf_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic awvalid,
	output logic awready,
	input wire logic [ADDR_W-1:0] awaddr,
	input wire logic wvalid,
	output logic wready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	input wire logic arvalid,
	output logic arready,
	input wire logic [ADDR_W-1:0] araddr,
	output logic rvalid,
	input wire logic rready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	input acf_dp_op_t dp_op,
	output logic [15:0] data_pointer,
	input wire logic timer_a_overflow,
	input wire logic timer_b_overflow,
	output logic timer_a_toggle_pin,
	output logic timer_b_toggle_pin,
	input wire logic uart_break_detect,
	output logic chip_reset_pulse,
	output logic isp_boot_request,
	output logic clock_low_power_select,
	input wire logic monitor_active,
	output acf_clk_en_t periph_clk_en,
	input wire logic reset_event,
	input wire logic [7:0] user_config_word_two,
	input wire logic sclk_pullup,
	input wire logic sdat_pullup,
	input wire logic debugger_present,
	output logic debug_mode
);
	acf_wstate_t ws_reg, ws_next;
	logic awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
	logic [1:0] bresp_reg, rresp_reg;
	logic [31:0] rdata_reg;
	logic [ADDR_W-1:0] awaddr_reg;
	logic [7:0] wdata_reg;
	logic wstrb0_reg;
	logic [7:0] aux_reg, frz_reg;
	logic ta_pin_reg, tb_pin_reg, soft_reset_request_reg, isp_reg;
	acf_clk_en_t clk_en_reg;
	logic [DBG_PINS-1:0] pin_meta_reg, pin_sync_reg;
	logic debug_mode_reg, rd_was_aux_reg;

	// write channel decode
	wire aw_hs = awvalid && awready_reg;
	wire w_hs = wvalid && wready_reg;
	wire wr_commit = (ws_reg != WS_RESP) && (ws_next == WS_RESP);
	wire [ADDR_W-1:0] wr_addr = aw_hs ? awaddr : awaddr_reg;
	wire [7:0] wr_byte = w_hs ? wdata[7:0] : wdata_reg;
	wire wr_lane0 = w_hs ? wstrb[0] : wstrb0_reg;
	wire wr_is_aux = wr_addr == AUX_ADDR;
	wire wr_is_frz = wr_addr == FRZ_ADDR;
	wire wr_aux = wr_commit && wr_is_aux && wr_lane0;
	wire wr_frz = wr_commit && wr_is_frz && wr_lane0;
	// software reset comes from any aux write carrying bit 3
	wire soft_rst = wr_aux && wr_byte[AUX_SOFT_RESET_REQUEST_BIT];
	wire brk_rst = uart_break_detect && aux_reg[AUX_BRK_BIT];

	// read channel decode
	wire ar_hs = arvalid && arready_reg;
	wire rd_is_aux = araddr == AUX_ADDR;
	wire rd_is_frz = araddr == FRZ_ADDR;
	wire rvalid_next = ar_hs || (rvalid_reg && !rready);
	wire [7:0] rd_byte = rd_is_aux ? aux_reg : (rd_is_frz ? frz_reg : 8'h00);
	wire halt_now = monitor_active && debug_mode_reg;
	wire dbg_cfg = user_config_word_two[DBG_CFG_BIT];
	wire [DBG_PINS-1:0] dbg_pins_in = {debugger_present, sdat_pullup, sclk_pullup};

	// write state: address and data may land in either order
	always_comb begin
		case (ws_reg)
			WS_IDLE: begin
				if (aw_hs && w_hs) ws_next = WS_RESP;
				else if (aw_hs) ws_next = WS_ADDR;
				else if (w_hs) ws_next = WS_DATA;
				else ws_next = WS_IDLE;
			end
			WS_ADDR: ws_next = w_hs ? WS_RESP : WS_ADDR;
			WS_DATA: ws_next = aw_hs ? WS_RESP : WS_DATA;
			WS_RESP: ws_next = bready ? WS_IDLE : WS_RESP;
			default: ws_next = WS_IDLE;
		endcase
	end

	// write channel registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ws_reg <= WS_IDLE;
			awready_reg <= 1'b0;
			wready_reg <= 1'b0;
			bvalid_reg <= 1'b0;
			bresp_reg <= RESP_OKAY;
		end else begin
			ws_reg <= ws_next;
			awready_reg <= (ws_next == WS_IDLE) || (ws_next == WS_DATA);
			wready_reg <= (ws_next == WS_IDLE) || (ws_next == WS_ADDR);
			bvalid_reg <= ws_next == WS_RESP;
			if (wr_commit) bresp_reg <= (wr_is_aux || wr_is_frz) ? RESP_OKAY : RESP_DECERR;
		end
	end

	// held halves of a split write, no reset needed for payload
	always_ff @(posedge aclk) begin
		if (aw_hs) awaddr_reg <= awaddr;
		if (w_hs) wdata_reg <= wdata[7:0];
		if (w_hs) wstrb0_reg <= wstrb[0];
	end

	// read channel: one read at a time, data registered at the handshake
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_reg <= 1'b0;
			rvalid_reg <= 1'b0;
			rdata_reg <= 32'h0000_0000;
			rresp_reg <= RESP_OKAY;
			rd_was_aux_reg <= 1'b0;
		end else begin
			arready_reg <= !rvalid_next;
			rvalid_reg <= rvalid_next;
			if (ar_hs) begin
				rdata_reg <= {24'h00_0000, rd_byte};
				rresp_reg <= (rd_is_aux || rd_is_frz) ? RESP_OKAY : RESP_DECERR;
				rd_was_aux_reg <= rd_is_aux;
			end
		end
	end

	// control registers; masks keep bits 1..3 and unused freeze bits at zero
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aux_reg <= AUX_RST;
			frz_reg <= FRZ_RST;
		end else begin
			if (wr_aux) aux_reg <= wr_byte & AUX_WMASK;
			if (wr_frz) frz_reg <= wr_byte & FRZ_WMASK;
		end
	end

	// soft reset leaves as a single pulse, a break request lasts while the break is seen; our own reset then clears the control registers and pointers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			soft_reset_request_reg <= 1'b0;
			isp_reg <= 1'b0;
		end else begin
			soft_reset_request_reg <= soft_rst || brk_rst;
			isp_reg <= brk_rst;
		end
	end

	// toggle pins flip on overflow; overflow pulses come from same-clock timers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ta_pin_reg <= 1'b0;
			tb_pin_reg <= 1'b0;
		end else begin
			ta_pin_reg <= ta_pin_reg ^ (timer_a_overflow && aux_reg[AUX_TA_BIT]);
			tb_pin_reg <= tb_pin_reg ^ (timer_b_overflow && aux_reg[AUX_TB_BIT]);
		end
	end

	// clock gates: frozen only while the debugger runs monitor code
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			clk_en_reg <= '1;
		end else begin
			clk_en_reg.timer_a <= !(halt_now && frz_reg[FRZ_TA_BIT]);
			clk_en_reg.timer_b <= !(halt_now && frz_reg[FRZ_TB_BIT]);
			clk_en_reg.watchdog <= !(halt_now && frz_reg[FRZ_WD_BIT]);
			clk_en_reg.rtc <= !(halt_now && frz_reg[FRZ_RTC_BIT]);
		end
	end

	// debugger pins are asynchronous, two stages before use
	for (genvar i = 0; i < DBG_PINS; i++) begin : g_sync
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				pin_meta_reg[i] <= 1'b0;
				pin_sync_reg[i] <= 1'b0;
			end else begin
				pin_meta_reg[i] <= dbg_pins_in[i];
				pin_sync_reg[i] <= pin_meta_reg[i];
			end
		end
	end

	// debug mode is decided only at a power-on or external reset event
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			debug_mode_reg <= 1'b0;
		end else if (reset_event) begin
			debug_mode_reg <= dbg_cfg && (&pin_sync_reg);
		end
	end

	acf_data_pointer_bank u_data_pointer (
		.aclk(aclk),
		.aresetn(aresetn),
		.pointer_select(aux_reg[AUX_SEL_BIT]),
		.dp_op(dp_op),
		.pointer_q(data_pointer)
	);

	// outputs straight from flops
	assign awready = awready_reg;
	assign wready = wready_reg;
	assign bvalid = bvalid_reg;
	assign bresp = bresp_reg;
	assign arready = arready_reg;
	assign rvalid = rvalid_reg;
	assign rdata = rdata_reg;
	assign rresp = rresp_reg;
	assign timer_a_toggle_pin = ta_pin_reg;
	assign timer_b_toggle_pin = tb_pin_reg;
	assign chip_reset_pulse = soft_reset_request_reg;
	assign isp_boot_request = isp_reg;
	assign clock_low_power_select = aux_reg[AUX_CLP_BIT];
	assign periph_clk_en = clk_en_reg;
	assign debug_mode = debug_mode_reg;

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	property p_sel_write;
		wr_aux |=> aux_reg[AUX_SEL_BIT] == $past(wr_byte[AUX_SEL_BIT]);
	endproperty
	a_sel_write: assert property (p_sel_write) else $error("pointer select not written");

	property p_spare_quiet;
		wr_aux && wr_byte == 8'h02 && !brk_rst |=> aux_reg == 8'h00 ##1 !chip_reset_pulse;
	endproperty
	a_spare_quiet: assert property (p_spare_quiet) else $error("spare bit had an effect");

	property p_zero_bits;
		rvalid && rd_was_aux_reg |-> rdata[31:1] == {rdata[31:4], 3'b000};
	endproperty
	a_zero_bits: assert property (p_zero_bits) else $error("aux bits 3..1 read nonzero");

	property p_soft_reset;
		soft_rst && !brk_rst |=> chip_reset_pulse && !isp_boot_request;
	endproperty
	a_soft_reset: assert property (p_soft_reset) else $error("soft reset not issued");

	property p_toggle_a;
		timer_a_overflow && aux_reg[AUX_TA_BIT] |=> timer_a_toggle_pin != $past(timer_a_toggle_pin);
	endproperty
	a_toggle_a: assert property (p_toggle_a) else $error("timer A pin did not toggle");

	property p_toggle_b;
		!(timer_b_overflow && aux_reg[AUX_TB_BIT]) |=> $stable(timer_b_toggle_pin);
	endproperty
	a_toggle_b: assert property (p_toggle_b) else $error("timer B pin moved alone");

	property p_break_reset;
		brk_rst |=> chip_reset_pulse && isp_boot_request;
	endproperty
	a_break_reset: assert property (p_break_reset) else $error("break did not reset to loader");

	property p_lp_reset;
		$rose(aresetn) |-> !clock_low_power_select;
	endproperty
	a_lp_reset: assert property (p_lp_reset) else $error("low power select not cleared");

	property p_freeze_timer;
		halt_now && frz_reg[FRZ_TA_BIT] && $stable(frz_reg) |=> !periph_clk_en.timer_a;
	endproperty
	a_freeze_timer: assert property (p_freeze_timer) else $error("timer A ran in monitor");

	property p_freeze_wd;
		halt_now && frz_reg[FRZ_WD_BIT] && frz_reg[FRZ_RTC_BIT] |=> !periph_clk_en.watchdog && !periph_clk_en.rtc;
	endproperty
	a_freeze_wd: assert property (p_freeze_wd) else $error("watchdog or rtc ran in monitor");

	property p_resume;
		!monitor_active [*2] |-> periph_clk_en == 4'b1111;
	endproperty
	a_resume: assert property (p_resume) else $error("clock held in user code");

	property p_debug_entry;
		!reset_event |=> $stable(debug_mode);
	endproperty
	a_debug_entry: assert property (p_debug_entry) else $error("debug mode changed without reset");

	property p_soft_reset_request_pulse;
		soft_rst ##1 !soft_rst && !brk_rst |=> !chip_reset_pulse && !aux_reg[AUX_SOFT_RESET_REQUEST_BIT];
	endproperty
	a_soft_reset_request_pulse: assert property (p_soft_reset_request_pulse) else $error("soft reset longer than a pulse");

	property p_frz_unused;
		wr_frz |=> frz_reg[7:5] == 3'b000 && !frz_reg[3];
	endproperty
	a_frz_unused: assert property (p_frz_unused) else $error("unused freeze bit stored");

	c_soft_reset: cover property (soft_rst);
	c_break_reset: cover property (brk_rst);
	c_frozen: cover property (halt_now && frz_reg[FRZ_TA_BIT] ##1 !periph_clk_en.timer_a);
	c_split_write: cover property (ws_reg == WS_DATA ##[1:4] ws_reg == WS_RESP);
endmodule : acf_aux_ctrl

// ==== verif/acf_core_model.sv ====
`timescale 1ns/100ps
// core-side register master; one write and one read at a time
module acf_core_model
	import acf_pkg::*;
(
	input wire logic aclk,
	output logic awvalid,
	input wire logic awready,
	output logic [ADDR_W-1:0] awaddr,
	output logic wvalid,
	input wire logic wready,
	output logic [31:0] wdata,
	output logic [3:0] wstrb,
	input wire logic bvalid,
	output logic bready,
	input wire logic [1:0] bresp,
	output logic arvalid,
	input wire logic arready,
	output logic [ADDR_W-1:0] araddr,
	input wire logic rvalid,
	output logic rready,
	input wire logic [31:0] rdata,
	input wire logic [1:0] rresp
);
	bit hang = 0;
	// bus idle from time zero
	initial begin
		{awvalid, wvalid, bready, arvalid, rready} = '0;
		{awaddr, araddr, wdata, wstrb} = '0;
	end
	// the caller decides what is written; the soft reset bit only goes out when a reset is meant
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d, output logic [1:0] r);
		int n;
		@(posedge aclk);
		awaddr <= a;
		wdata <= {24'h00_0000, d};
		wstrb <= 4'h1;
		{awvalid, wvalid, bready} <= 3'b111;
		for (n = 0; n < 64; n++) begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid) begin
				r = bresp;
				bready <= 1'b0;
				break;
			end
		end
		if (n == 64) hang = 1;
	endtask : wr
	// read; rready stays up until the answer is sampled
	task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		@(posedge aclk);
		araddr <= a;
		{arvalid, rready} <= 2'b11;
		for (n = 0; n < 64; n++) begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
			if (rvalid) begin
				d = rdata;
				r = rresp;
				rready <= 1'b0;
				break;
			end
		end
		if (n == 64) hang = 1;
	endtask : rd
endmodule : acf_core_model

// ==== verif/tb.sv ====
`timescale 1ns/100ps
`define CHK(n, e, s) begin checks++; if ((e) !== (s)) begin failures++; $display("Error %s expected %h seen %h", n, e, s); end end
module tb
	import acf_pkg::*;
;
	logic aclk = 0, aresetn = 0;
	logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	logic [ADDR_W-1:0] awaddr, araddr;
	logic [31:0] wdata, rdata, rv;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, resp;
	acf_dp_op_t dp_op = '0;
	logic [15:0] data_pointer, pa, pb;
	logic ta_ovf = 0, tb_ovf = 0, brk = 0, mon = 0, rst_ev = 0, sclk_pu = 0, sdat_pu = 0, dbg_on = 0;
	logic [7:0] cfg = '0, d, f;
	logic ta_pin, tb_pin, crst, isp, clp, dbg, ra, rb, ta_e = 0, tb_e = 0;
	acf_clk_en_t clk_en;
	int failures = 0, checks = 0, n_crst = 0, n_isp = 0, k, j;
	always #5 aclk = ~aclk;
	// count pulse cycles so both width and origin of a reset can be judged
	always @(posedge aclk) begin
		if (crst === 1'b1) n_crst <= n_crst + 1;
		if (isp === 1'b1) n_isp <= n_isp + 1;
	end
	acf_aux_ctrl u_acf_aux_ctrl(.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
		.awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid),
		.bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
		.rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp), .dp_op(dp_op),
		.data_pointer(data_pointer), .timer_a_overflow(ta_ovf), .timer_b_overflow(tb_ovf),
		.timer_a_toggle_pin(ta_pin), .timer_b_toggle_pin(tb_pin), .uart_break_detect(brk),
		.chip_reset_pulse(crst), .isp_boot_request(isp), .clock_low_power_select(clp),
		.monitor_active(mon), .periph_clk_en(clk_en), .reset_event(rst_ev), .user_config_word_two(cfg),
		.sclk_pullup(sclk_pu), .sdat_pullup(sdat_pu), .debugger_present(dbg_on), .debug_mode(dbg));
	acf_core_model u_acf_core_model(.aclk(aclk), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
		.wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
		.bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid),
		.rready(rready), .rdata(rdata), .rresp(rresp));
	task automatic print_verdict;
		if (failures == 0 && checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : print_verdict
	// a stuck bus ends the run at once
	task automatic hung;
		if (u_acf_core_model.hang) begin
			failures++;
			print_verdict;
		end
	endtask : hung
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] v);
		u_acf_core_model.wr(a, v, resp);
		hung;
	endtask : wr
	task automatic rd(input logic [ADDR_W-1:0] a);
		u_acf_core_model.rd(a, rv, resp);
		hung;
	endtask : rd
	// one core pointer op, then wait the two edges the pointer needs to show
	task automatic dpop(input acf_dp_op_t op, input logic [15:0] e);
		@(posedge aclk);
		dp_op <= op;
		@(posedge aclk);
		dp_op <= '0;
		repeat (2) @(posedge aclk);
		#1;
		`CHK("pointer", e, data_pointer)
	endtask : dpop
	task automatic pulse(input logic a, input logic b, input logic c);
		@(posedge aclk);
		{ta_ovf, tb_ovf, brk} <= {a, b, c};
		@(posedge aclk);
		{ta_ovf, tb_ovf, brk} <= 3'b000;
		#1;
	endtask : pulse
	task automatic do_reset;
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
	endtask : do_reset
	initial begin
		void'($urandom(4));
		do_reset;
		rd(AUX_ADDR);
		`CHK("aux", 32'h0000_0000, rv)
		rd(FRZ_ADDR);
		`CHK("freeze", 32'h0000_0000, rv)
		`CHK("clk_en", 4'hf, clk_en)
		// unmapped place: refused, registers untouched
		wr(18'h0_0004, 8'hff);
		`CHK("bresp", 2'b11, resp)
		rd(18'h0_0004);
		`CHK("rresp", 2'b11, resp)
		rd(AUX_ADDR);
		`CHK("aux", 32'h0000_0000, rv)
		// spare bit alone: stored nowhere and no reset pulse
		k = n_crst;
		wr(AUX_ADDR, 8'h02);
		rd(AUX_ADDR);
		`CHK("aux", 32'h0000_0000, rv)
		repeat (2) @(posedge aclk);
		`CHK("spare_rst", k, n_crst)
		// random writes with the soft reset bit held clear; monitor on but no debug mode
		mon <= 1'b1;
		for (int i = 0; i < 8; i++) begin
			d = $urandom;
			d[3] = 1'b0;
			wr(AUX_ADDR, d);
			`CHK("bresp", RESP_OKAY, resp)
			rd(AUX_ADDR);
			`CHK("rresp", RESP_OKAY, resp)
			`CHK("aux", {24'h00_0000, d & 8'hf1}, rv)
			`CHK("clp", d[7], clp)
			f = $urandom;
			wr(FRZ_ADDR, f);
			rd(FRZ_ADDR);
			`CHK("freeze", {24'h00_0000, f & 8'h17}, rv)
			`CHK("clk_en", 4'hf, clk_en)
		end
		mon <= 1'b0;
		// dual pointers: the hidden one keeps its value, carry across the top
		pa = 16'hffff;
		pb = $urandom;
		d = $urandom;
		wr(AUX_ADDR, 8'h00);
		dpop({4'b0100, pa}, pa);
		wr(AUX_ADDR, 8'h01);
		dpop({4'b0100, pb}, pb);
		wr(AUX_ADDR, 8'h00);
		dpop('0, pa);
		dpop({4'b1000, 16'h0000}, 16'h0000);
		dpop({4'b0010, d, 8'h00}, {d, 8'h00});
		dpop({4'b0001, 8'h00, ~d}, {d, ~d});
		dpop({4'b1100, pb}, pb);
		wr(AUX_ADDR, 8'h07);
		dpop('0, pb);
		// every toggle-enable pairing against random overflows
		for (int i = 0; i < 4; i++) begin
			wr(AUX_ADDR, {2'b00, i[1:0], 4'h0});
			repeat (4) begin
				ra = $urandom;
				rb = $urandom;
				pulse(ra, rb, 1'b0);
				ta_e = ta_e ^ (ra & i[0]);
				tb_e = tb_e ^ (rb & i[1]);
				`CHK("pin_a", ta_e, ta_pin)
				`CHK("pin_b", tb_e, tb_pin)
			end
		end
		// break: ignored while disabled, reset plus loader entry when enabled
		k = n_crst;
		j = n_isp;
		pulse(1'b0, 1'b0, 1'b1);
		repeat (3) @(posedge aclk);
		`CHK("brk_off", k, n_crst)
		wr(AUX_ADDR, 8'h40);
		pulse(1'b0, 1'b0, 1'b1);
		repeat (3) @(posedge aclk);
		`CHK("brk_rst", k + 1, n_crst)
		`CHK("brk_isp", j + 1, n_isp)
		// soft reset: a single pulse, bit never reads back, then the chip reset clears aux, pointer and low power select
		wr(AUX_ADDR, 8'h09);
		repeat (3) @(posedge aclk);
		`CHK("soft_reset_request", k + 2, n_crst)
		`CHK("soft_reset_request_isp", j + 1, n_isp)
		rd(AUX_ADDR);
		`CHK("aux", 32'h0000_0001, rv)
		do_reset;
		rd(AUX_ADDR);
		`CHK("aux", 32'h0000_0000, rv)
		`CHK("pointer", 16'h0000, data_pointer)
		`CHK("clp", 1'b0, clp)
		// debug entry needs all four conditions; freeze only bites inside debug mode
		for (int i = 0; i < 5; i++) begin
			@(posedge aclk);
			{cfg[5], sclk_pu, sdat_pu, dbg_on} <= ~(4'b1000 >> i);
			repeat (3) @(posedge aclk);
			rst_ev <= 1'b1;
			@(posedge aclk);
			rst_ev <= 1'b0;
			f = $urandom;
			wr(FRZ_ADDR, f);
			mon <= 1'b1;
			repeat (3) @(posedge aclk);
			#1;
			`CHK("debug", (i == 4), dbg)
			`CHK("frozen", (i == 4) ? ~{f[4], f[2:0]} : 4'hf, clk_en)
			@(posedge aclk);
			mon <= 1'b0;
			repeat (2) @(posedge aclk);
			#1;
			`CHK("resumed", 4'hf, clk_en)
		end
		print_verdict;
	end
	// hang guard for the whole run
	initial begin
		repeat (20000) @(posedge aclk);
		failures++;
		print_verdict;
	end
endmodule : tb
